// *** src/port_dma_burst_write_fsm.sv ***
// Port DMA burst write state machine driving the multiplexed address/data bus
`timescale 1ns/10ps

module port_dma_burst_write_fsm #(
    parameter int DATA_W  = dma_write_pkg::DATA_W,
    parameter int COUNT_W = dma_write_pkg::COUNT_W
) (
    input  wire logic               ref_clk_in,
    input  wire logic               rst_in,
    // Pins from the outside arbitration and target logic
    input  wire logic               address_phase_select_n_in,
    input  wire logic               target_ready_n_in,
    input  wire logic               comm_register_select_in,
    // Address/data bus: level in, drive out, enable low while driving
    input  wire logic [DATA_W-1:0]  port_addr_data_bus_in,
    output logic      [DATA_W-1:0]  port_addr_data_bus_out,
    output logic                    port_addr_data_bus_oe_n_out,
    output logic                    source_valid_n_out,
    output logic                    source_valid_oe_n_out,
    output logic                    final_transfer_n_out,
    output logic                    final_transfer_oe_n_out,
    output logic                    bus_request_n_out,
    // DMA engine side, same clock
    input  wire logic               write_request_in,
    input  wire logic [DATA_W-1:0]  burst_addr_in,
    input  wire logic [COUNT_W-1:0] burst_words_in,
    input  wire logic [DATA_W-1:0]  write_data_in,
    output logic                    write_data_taken_out,
    output logic                    burst_done_out,
    output logic                    busy_out
);

    localparam int SYNC_STAGES = dma_write_pkg::SYNC_STAGES;

    // Two-stage synchronisers for the pin inputs
    logic [SYNC_STAGES-1:0] phase_sel_sync_q;
    logic [SYNC_STAGES-1:0] ready_sync_q;
    logic [SYNC_STAGES-1:0] comm_sync_q;

    logic phase_sel_hi;
    logic ready_hi;
    logic comm_sel;
    logic last_word_flag;

    dma_write_pkg::wr_state_e state_q;
    dma_write_pkg::wr_state_e state_d;
    dma_write_pkg::bus_mode_e mode_q;
    dma_write_pkg::bus_mode_e mode_d;

    logic [DATA_W-1:0] bus_data_q;
    logic [DATA_W-1:0] bus_data_d;
    logic              src_valid_n_q;
    logic              src_valid_n_d;
    logic              final_n_q;
    logic              final_n_d;
    logic              strobe_oe_n_q;
    logic              strobe_oe_n_d;
    logic              req_pending_q;
    logic              req_pending_d;
    logic              done_q;
    logic              done_d;

    logic enter_addr;
    logic send_word;

    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            phase_sel_sync_q <= '1;
            ready_sync_q     <= '1;
            comm_sync_q      <= '0;
        end
        else
        begin
            phase_sel_sync_q <= {phase_sel_sync_q[0], address_phase_select_n_in};
            ready_sync_q     <= {ready_sync_q[0], target_ready_n_in};
            comm_sync_q      <= {comm_sync_q[0], comm_register_select_in};
        end
    end

    assign phase_sel_hi = phase_sel_sync_q[SYNC_STAGES-1];
    assign ready_hi     = ready_sync_q[SYNC_STAGES-1];
    assign comm_sel     = comm_sync_q[SYNC_STAGES-1];

    // Tri-state variant that remembers the state it was entered from, except Idle, which enters the clean-up variant
    function automatic dma_write_pkg::wr_state_e tri_variant(input dma_write_pkg::wr_state_e cur);
        dma_write_pkg::wr_state_e res;
        res = cur;
        unique case (cur)
            dma_write_pkg::ST_ADDR:   res = dma_write_pkg::ST_TS_ADDR;
            dma_write_pkg::ST_DWRITE: res = dma_write_pkg::ST_TS_DWRITE;
            dma_write_pkg::ST_DWAIT:  res = dma_write_pkg::ST_TS_DWAIT;
            dma_write_pkg::ST_LAST:   res = dma_write_pkg::ST_TS_LAST;
            dma_write_pkg::ST_CLEAN:  res = dma_write_pkg::ST_TS_CLEAN;
            dma_write_pkg::ST_IDLE:   res = dma_write_pkg::ST_TS_CLEAN;
            default:                  res = cur;
        endcase
        return res;
    endfunction

    // Next state and the bus condition it shows
    always_comb
    begin
        state_d = state_q;
        mode_d  = mode_q;
        if (comm_sel)
        begin
            // Comm register machine owns the port; keep the bus released
            state_d = tri_variant(state_q);
            mode_d  = dma_write_pkg::BUS_TRI;
        end
        else if (!phase_sel_hi && ready_hi)
        begin
            state_d = tri_variant(state_q);
            mode_d  = dma_write_pkg::BUS_TRI;
        end
        else if (!phase_sel_hi && !ready_hi)
        begin
            state_d = dma_write_pkg::ST_ADDR;
            mode_d  = dma_write_pkg::BUS_ADDR;
        end
        else if (ready_hi)
        begin
            unique case (state_q)
                dma_write_pkg::ST_LAST:
                begin
                    state_d = dma_write_pkg::ST_CLEAN;
                    mode_d  = dma_write_pkg::BUS_DONT;
                end
                dma_write_pkg::ST_IDLE:
                begin
                    state_d = dma_write_pkg::ST_IDLE;
                    mode_d  = dma_write_pkg::BUS_TRI;
                end
                default:
                begin
                    state_d = dma_write_pkg::ST_DWAIT;
                    mode_d  = dma_write_pkg::BUS_DONT;
                end
            endcase
        end
        else
        begin
            unique case (state_q)
                dma_write_pkg::ST_IDLE,
                dma_write_pkg::ST_ADDR,
                dma_write_pkg::ST_DWRITE,
                dma_write_pkg::ST_DWAIT,
                dma_write_pkg::ST_TS_ADDR,
                dma_write_pkg::ST_TS_DWRITE,
                dma_write_pkg::ST_TS_DWAIT:
                begin
                    if (last_word_flag)
                    begin
                        state_d = dma_write_pkg::ST_LAST;
                    end
                    else
                    begin
                        state_d = dma_write_pkg::ST_DWRITE;
                    end
                    mode_d = dma_write_pkg::BUS_DATA;
                end
                dma_write_pkg::ST_LAST:
                begin
                    state_d = dma_write_pkg::ST_CLEAN;
                    mode_d  = dma_write_pkg::BUS_DONT;
                end
                dma_write_pkg::ST_CLEAN:
                begin
                    state_d = dma_write_pkg::ST_IDLE;
                    mode_d  = dma_write_pkg::BUS_TRI;
                end
                dma_write_pkg::ST_TS_LAST,
                dma_write_pkg::ST_TS_CLEAN:
                begin
                    state_d = dma_write_pkg::ST_DWRITE;
                    mode_d  = dma_write_pkg::BUS_DONT;
                end
                default:
                begin
                    state_d = dma_write_pkg::ST_IDLE;
                    mode_d  = dma_write_pkg::BUS_TRI;
                end
            endcase
        end
    end

    assign enter_addr = (mode_d == dma_write_pkg::BUS_ADDR);
    assign send_word  = (mode_d == dma_write_pkg::BUS_DATA);

    // Registered pin values for the next cycle
    always_comb
    begin
        bus_data_d    = bus_data_q;
        src_valid_n_d = 1'h1;
        final_n_d     = 1'h1;
        strobe_oe_n_d = dma_write_pkg::STROBE_OE_N;
        unique case (mode_d)
            dma_write_pkg::BUS_ADDR:
            begin
                bus_data_d = burst_addr_in;
            end
            dma_write_pkg::BUS_DATA:
            begin
                bus_data_d    = write_data_in;
                src_valid_n_d = 1'h0;
            end
            dma_write_pkg::BUS_DONT:
            begin
                bus_data_d = bus_data_q;
            end
            dma_write_pkg::BUS_TRI:
            begin
                bus_data_d = bus_data_q;
            end
        endcase
        if (state_d == dma_write_pkg::ST_LAST)
        begin
            final_n_d = 1'h0;
        end
        if (mode_d == dma_write_pkg::BUS_TRI && state_d != dma_write_pkg::ST_IDLE)
        begin
            strobe_oe_n_d = ~dma_write_pkg::STROBE_OE_N;
        end
    end

    // Request to the arbiter; a new request wins over the clear at Address
    always_comb
    begin
        req_pending_d = req_pending_q;
        if (enter_addr)
        begin
            req_pending_d = 1'h0;
        end
        if (write_request_in)
        begin
            req_pending_d = 1'h1;
        end
        done_d = (state_q == dma_write_pkg::ST_LAST) && (state_d == dma_write_pkg::ST_CLEAN);
    end

    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state_q       <= dma_write_pkg::STATE_RST;
            mode_q        <= dma_write_pkg::MODE_RST;
            bus_data_q    <= '0;
            src_valid_n_q <= dma_write_pkg::STROBE_RST;
            final_n_q     <= dma_write_pkg::STROBE_RST;
            strobe_oe_n_q <= dma_write_pkg::STROBE_OE_N;
            req_pending_q <= dma_write_pkg::REQ_RST;
            done_q        <= 1'h0;
        end
        else
        begin
            state_q       <= state_d;
            mode_q        <= mode_d;
            bus_data_q    <= bus_data_d;
            src_valid_n_q <= src_valid_n_d;
            final_n_q     <= final_n_d;
            strobe_oe_n_q <= strobe_oe_n_d;
            req_pending_q <= req_pending_d;
            done_q        <= done_d;
        end
    end

    burst_word_counter #(
        .COUNT_W (COUNT_W)
    ) u_word_counter (
        .ref_clk_in         (ref_clk_in),
        .rst_in             (rst_in),
        .load_in            (enter_addr),
        .load_words_in      (burst_words_in),
        .consume_in         (send_word),
        .last_word_flag_out (last_word_flag)
    );

    assign port_addr_data_bus_out      = bus_data_q;
    assign port_addr_data_bus_oe_n_out = (mode_q == dma_write_pkg::BUS_TRI);
    assign source_valid_n_out          = src_valid_n_q;
    assign source_valid_oe_n_out       = strobe_oe_n_q;
    assign final_transfer_n_out        = final_n_q;
    assign final_transfer_oe_n_out     = strobe_oe_n_q;
    assign bus_request_n_out           = ~req_pending_q;
    assign write_data_taken_out        = send_word;
    assign burst_done_out              = done_q;
    assign busy_out                    = (state_q != dma_write_pkg::ST_IDLE);

    // Bus level is only observed by the outside; write bursts never read it
    logic unused_bus_in;
    assign unused_bus_in = ^port_addr_data_bus_in;

endmodule

// *** pkg/dma_write_pkg.sv ***
// Shared types and constants for the port DMA burst write machine
package dma_write_pkg;

    // Burst write machine states
    typedef enum logic [3:0] {
        ST_IDLE      = 4'h0,
        ST_ADDR      = 4'h1,
        ST_DWRITE    = 4'h2,
        ST_DWAIT     = 4'h3,
        ST_LAST      = 4'h4,
        ST_CLEAN     = 4'h5,
        ST_TS_ADDR   = 4'h6,
        ST_TS_DWRITE = 4'h7,
        ST_TS_DWAIT  = 4'h8,
        ST_TS_LAST   = 4'h9,
        ST_TS_CLEAN  = 4'ha
    } wr_state_e;

    // What the shared address/data bus carries in a cycle
    typedef enum logic [1:0] {
        BUS_TRI  = 2'h0,
        BUS_ADDR = 2'h1,
        BUS_DATA = 2'h2,
        BUS_DONT = 2'h3
    } bus_mode_e;

    localparam int        DATA_W       = 32;
    localparam int        COUNT_W      = 8;
    localparam int        SYNC_STAGES  = 2;
    localparam wr_state_e STATE_RST    = ST_IDLE;
    localparam bus_mode_e MODE_RST     = BUS_TRI;
    localparam logic      STROBE_RST   = 1'h1;
    localparam logic      STROBE_OE_N  = 1'h0;
    localparam logic      REQ_RST      = 1'h0;

endpackage

// *** src/burst_word_counter.sv ***
// Word-count logic: counts remaining data words and raises the last-word flag
`timescale 1ns/10ps

module burst_word_counter #(
    parameter int COUNT_W = dma_write_pkg::COUNT_W
) (
    input  wire logic               ref_clk_in,
    input  wire logic               rst_in,
    input  wire logic               load_in,
    input  wire logic [COUNT_W-1:0] load_words_in,
    input  wire logic               consume_in,
    output logic                    last_word_flag_out
);

    logic [COUNT_W-1:0] remain_q;
    logic [COUNT_W-1:0] remain_d;

    // Remaining words still to go out after the one now on the bus
    always_comb
    begin
        remain_d = remain_q;
        if (load_in)
        begin
            remain_d = load_words_in;
        end
        else if (consume_in && (remain_q != '0))
        begin
            remain_d = remain_q - COUNT_W'(1);
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            remain_q <= '0;
        end
        else
        begin
            remain_q <= remain_d;
        end
    end

    // High while the current data cycle is the one before the final word
    assign last_word_flag_out = (remain_q == COUNT_W'(1));

endmodule

// *** verif/dma_write_checker_sva.sv ***
// Port-level checks for the burst write machine
`timescale 1ns/10ps
module dma_write_checker (
    input  wire logic ref_clk_in,
    input  wire logic rst_in,
    input  wire logic address_phase_select_n_in,
    input  wire logic target_ready_n_in,
    input  wire logic comm_register_select_in,
    input  wire logic port_addr_data_bus_oe_n_out,
    input  wire logic source_valid_n_out,
    input  wire logic source_valid_oe_n_out,
    input  wire logic final_transfer_n_out,
    input  wire logic final_transfer_oe_n_out,
    input  wire logic burst_done_out,
    input  wire logic busy_out
);
    logic      [2:0] arm_q;
    wire logic       sel = address_phase_select_n_in & ~comm_register_select_in;
    wire logic       go_c = ~address_phase_select_n_in & ~target_ready_n_in & ~comm_register_select_in;
    wire logic       tri_c = ~address_phase_select_n_in & target_ready_n_in;
    wire logic       dat_c = sel & ~target_ready_n_in;
    wire logic       hold_c = sel & target_ready_n_in;
    wire logic       oe_n = port_addr_data_bus_oe_n_out;
    wire logic       sv_n = source_valid_n_out;
    wire logic       ft_n = final_transfer_n_out;

    // Pins reach the outputs three edges later, so wait out the pipeline after reset
    always_ff @(posedge ref_clk_in or posedge rst_in)
        if (rst_in)
            arm_q <= 3'h0;
        else if (arm_q != 3'h5)
            arm_q <= arm_q + 3'h1;

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (rst_in);

    property p_release;
        arm_q > 3'h2 && $past(tri_c, 3) |-> oe_n && source_valid_oe_n_out && final_transfer_oe_n_out;
    endproperty
    a_release: assert property (p_release) else $error("port kept driven in tri-state");
    property p_address;
        arm_q > 3'h2 && $past(go_c, 3) |-> !oe_n && sv_n && ft_n && !source_valid_oe_n_out;
    endproperty
    a_address: assert property (p_address) else $error("address cycle not entered");
    property p_hold;
        arm_q > 3'h2 && $past(hold_c, 3) |-> sv_n && ft_n;
    endproperty
    a_hold: assert property (p_hold) else $error("strobe low while target not ready");
    property p_valid;
        !sv_n |-> !oe_n && !source_valid_oe_n_out && $past(dat_c, 3);
    endproperty
    a_valid: assert property (p_valid) else $error("source valid without data cycle");
    property p_final;
        !ft_n && !final_transfer_oe_n_out |-> !sv_n && !oe_n;
    endproperty
    a_final: assert property (p_final) else $error("final strobe outside last transfer");
    property p_cleanup;
        !ft_n && !final_transfer_oe_n_out ##1 $past(sel, 3) |-> sv_n && ft_n && !oe_n && burst_done_out;
    endproperty
    a_cleanup: assert property (p_cleanup) else $error("last transfer not followed by clean up");
    property p_turn;
        arm_q > 3'h3 && $past(go_c, 4) && $past(dat_c, 3) |-> !sv_n && !oe_n;
    endproperty
    a_turn: assert property (p_turn) else $error("gap between address and data");
    property p_idle;
        burst_done_out && $past(dat_c, 2) |=> oe_n && sv_n && !busy_out;
    endproperty
    a_idle: assert property (p_idle) else $error("clean up did not return to idle");
    property p_quiet;
        !busy_out |-> oe_n && sv_n && ft_n && !source_valid_oe_n_out;
    endproperty
    a_quiet: assert property (p_quiet) else $error("idle port not quiet");
endmodule

bind port_dma_burst_write_fsm dma_write_checker chk (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .address_phase_select_n_in(address_phase_select_n_in),
    .target_ready_n_in(target_ready_n_in),
    .comm_register_select_in(comm_register_select_in),
    .port_addr_data_bus_oe_n_out(port_addr_data_bus_oe_n_out),
    .source_valid_n_out(source_valid_n_out),
    .source_valid_oe_n_out(source_valid_oe_n_out),
    .final_transfer_n_out(final_transfer_n_out),
    .final_transfer_oe_n_out(final_transfer_oe_n_out),
    .burst_done_out(burst_done_out),
    .busy_out(busy_out)
);

// *** verif/far_side_target.sv ***
// Outside arbiter and target model: drives the selects and logs what the port writes
`timescale 1ns/10ps
module far_side_target (
    input  wire logic        ref_clk_in,
    input  wire logic        sel_cmd_in,
    input  wire logic        rdy_cmd_in,
    input  wire logic [31:0] bus_in,
    input  wire logic        bus_oe_n_in,
    input  wire logic        valid_n_in,
    input  wire logic        strobe_oe_n_in,
    input  wire logic        final_n_in,
    output logic             address_phase_select_n_out,
    output logic             target_ready_n_out,
    output logic             comm_register_select_out
);
    logic [31:0] words[$];
    logic [31:0] lead_word;
    logic        oe_n_prev = 1'h1;
    int          finals = 0;
    int          holds = 0;
    int          tris = 0;

    assign address_phase_select_n_out = sel_cmd_in;
    assign target_ready_n_out         = rdy_cmd_in;
    assign comm_register_select_out   = 1'h0;

    always @(posedge ref_clk_in)
    begin
        oe_n_prev <= bus_oe_n_in;
        if (!bus_oe_n_in && oe_n_prev)
            lead_word <= bus_in;
        if (strobe_oe_n_in)
            tris <= tris + 1;
        else if (!valid_n_in)
            words.push_back(bus_in);
        else if (!bus_oe_n_in)
            holds <= holds + 1;
        if (!final_n_in && !strobe_oe_n_in)
            finals <= finals + 1;
    end
endmodule

// *** verif/port_dma_burst_write_fsm_test.sv ***
// Self-checking bench for the port burst write machine
`timescale 1ns/10ps
module port_dma_burst_write_fsm_test;
    localparam logic [31:0] BASE = 32'h5a000000;
    logic        ref_clk_in = 1'h0;
    logic        rst_in     = 1'h1;
    logic        sel_cmd    = 1'h1;
    logic        rdy_cmd    = 1'h1;
    logic        wr_req     = 1'h0;
    logic [31:0] addr       = 32'h0;
    logic [31:0] wdata      = BASE;
    logic [7:0]  nwords     = 8'h0;
    logic [31:0] bus_out, bus_lvl;
    logic        phase_sel_n, ready_n, comm, oe_n, sv_n, sv_oe_n, ft_n, ft_oe_n, req_n, taken, done, busy;
    int          fails = 0, checks_done = 0, cycles = 0, idx = 0, dones = 0, i0, w0, f0, h0, t0, d0;

    assign bus_lvl = oe_n ? ~bus_out : bus_out;
    always #4 ref_clk_in = ~ref_clk_in;
    always @(posedge ref_clk_in) if (taken) idx <= idx + 1;
    always @(posedge ref_clk_in) if (done) dones <= dones + 1;
    always @(negedge ref_clk_in) wdata = BASE + 32'(idx);
    always @(posedge ref_clk_in)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fails++;
            complete_run;
        end
    end

    far_side_target far (.ref_clk_in(ref_clk_in), .sel_cmd_in(sel_cmd), .rdy_cmd_in(rdy_cmd), .bus_in(bus_lvl),
        .bus_oe_n_in(oe_n), .valid_n_in(sv_n), .strobe_oe_n_in(sv_oe_n), .final_n_in(ft_n),
        .address_phase_select_n_out(phase_sel_n), .target_ready_n_out(ready_n), .comm_register_select_out(comm));
    port_dma_burst_write_fsm dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .address_phase_select_n_in(phase_sel_n),
        .target_ready_n_in(ready_n), .comm_register_select_in(comm), .port_addr_data_bus_in(bus_lvl),
        .port_addr_data_bus_out(bus_out), .port_addr_data_bus_oe_n_out(oe_n), .source_valid_n_out(sv_n),
        .source_valid_oe_n_out(sv_oe_n), .final_transfer_n_out(ft_n), .final_transfer_oe_n_out(ft_oe_n),
        .bus_request_n_out(req_n), .write_request_in(wr_req), .burst_addr_in(addr), .burst_words_in(nwords),
        .write_data_in(wdata), .write_data_taken_out(taken), .burst_done_out(done), .busy_out(busy));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One select/ready pair per cycle, changed on the falling edge
    task automatic pins(input logic s, input logic r, input int n);
        repeat (n)
        begin
            @(negedge ref_clk_in);
            sel_cmd = s;
            rdy_cmd = r;
        end
    endtask

    task automatic start(input logic [7:0] n);
        nwords = n;
        addr = addr + 32'h00000104;
        i0 = idx;
        w0 = far.words.size();
        f0 = far.finals;
        h0 = far.holds;
        t0 = far.tris;
        d0 = dones;
    endtask

    task automatic settle(input string name, input int nw, input int nf, input int nh, input int nt);
        repeat (5) @(negedge ref_clk_in);
        check("words", far.words.size() - w0, nw);
        for (int i = 0; i < nw; i++)
            check("word", far.words[w0 + i], BASE + 32'(i0 + i));
        check("finals", far.finals - f0, nf);
        check("holds", far.holds - h0, nh);
        check("tris", far.tris - t0, nt);
        check("done", dones - d0, nf);
        check("busy", busy, 1'h0);
        $display("Test %s done", name);
    endtask

    task automatic reset_values;
        @(negedge ref_clk_in);
        check("bus oe", oe_n, 1'h1);
        check("strobes", {sv_n, sv_oe_n, ft_n, ft_oe_n}, 4'ha);
        check("request", req_n, 1'h1);
        $display("Test reset done");
    endtask

    task automatic burst_plain;
        start(8'h3);
        wr_req = 1'h1;
        @(negedge ref_clk_in);
        wr_req = 1'h0;
        check("request", req_n, 1'h0);
        pins(1'h0, 1'h0, 1);
        pins(1'h1, 1'h0, 5);
        pins(1'h1, 1'h1, 1);
        settle("plain", 3, 1, 2, 0);
        check("address", far.lead_word, addr);
        check("request", req_n, 1'h1);
    endtask

    task automatic burst_wait;
        start(8'h3);
        pins(1'h0, 1'h0, 1);
        pins(1'h1, 1'h0, 1);
        pins(1'h1, 1'h1, 2);
        pins(1'h1, 1'h0, 1);
        pins(1'h1, 1'h1, 1);
        pins(1'h1, 1'h0, 3);
        pins(1'h1, 1'h1, 1);
        settle("wait", 3, 1, 5, 0);
    endtask

    task automatic burst_abort;
        start(8'h3);
        pins(1'h0, 1'h0, 1);
        pins(1'h1, 1'h0, 1);
        pins(1'h0, 1'h1, 2);
        pins(1'h1, 1'h0, 1);
        pins(1'h0, 1'h0, 1);
        pins(1'h1, 1'h0, 5);
        pins(1'h1, 1'h1, 1);
        settle("abort", 5, 1, 3, 2);
    endtask

    task automatic burst_late_tri;
        start(8'h1);
        pins(1'h0, 1'h0, 1);
        pins(1'h1, 1'h0, 2);
        pins(1'h0, 1'h1, 2);
        pins(1'h1, 1'h0, 1);
        pins(1'h0, 1'h0, 1);
        pins(1'h1, 1'h0, 3);
        pins(1'h1, 1'h1, 1);
        settle("late tri", 2, 2, 5, 2);
    endtask

    task automatic complete_run;
        $display("Checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        repeat (3) @(negedge ref_clk_in);
        rst_in = 1'h0;
        reset_values;
        burst_plain;
        burst_wait;
        burst_abort;
        burst_late_tri;
        complete_run;
    end
endmodule
